// ==== fawp_array_model.sv ====
// Flash array and free running flash clock source model
`timescale 1ns/10ps
module fawp_array_model (
  input wire [23:0] array_addr,
  output wire [31:0] array_data,
  output reg flash_clk_tick
);
  assign array_data = {8'h5A, array_addr};
  initial begin
    flash_clk_tick = 1'b0;
    #37;
    forever #100 flash_clk_tick = ~flash_clk_tick;
  end
endmodule // fawp_array_model

// ==== fawp_asserts.sv ====
// Checker for read handshake and program/erase outcomes
`timescale 1ns/10ps
module fawp_asserts (
  input wire clk,
  input wire rst_b,
  input wire rd_req,
  input wire rd_ack,
  input wire multi_module_read,
  input wire pe_req,
  input wire [2:0] pe_module,
  input wire pe_busy,
  input wire pe_done,
  input wire pe_refused
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_pe_take;
    pe_req && !pe_busy;
  endsequence
  sequence s_pe_run;
    pe_busy [*8];
  endsequence
  AST_ACK_PULSE: assert property (rd_ack |=> !rd_ack)
    else $error("read ack too long");
  AST_NO_EARLY_ACK: assert property ($rose(rd_req) |-> !rd_ack)
    else $error("read ack at take");
  AST_ACK_BOUND: assert property ($rose(rd_req) && !pe_busy |-> ##[1:9] rd_ack)
    else $error("read ack late");
  AST_ACK_HAS_REQ: assert property (rd_ack |-> $past(rd_req))
    else $error("read ack without request");
  AST_SPARE_ONLY: assert property (s_pe_take ##0 multi_module_read
    && pe_module != 3'h6 |=> pe_refused)
    else $error("non-spare module accepted");
  AST_REFUSE_IDLE: assert property (pe_refused |-> !pe_busy)
    else $error("refused operation started");
  AST_PE_MIN: assert property ($rose(pe_busy) |-> s_pe_run)
    else $error("operation too short");
  AST_PE_DONE: assert property ($rose(pe_busy) |-> ##[1:400] pe_done)
    else $error("operation never done");
  AST_DONE_PULSE: assert property (pe_done |=> !pe_done)
    else $error("done too long");
endmodule // fawp_asserts
bind fawp_flash_ctrl fawp_asserts fawp_asserts_inst (.clk, .rst_b, .rd_req, .rd_ack,
  .multi_module_read, .pe_req, .pe_module, .pe_busy, .pe_done, .pe_refused);

// ==== fawp_defines.vh ====
// Constants for the flash access, wait-state and program/erase control block
`ifndef FAWP_DEFINES_VH
`define FAWP_DEFINES_VH
`define FAWP_WS_W 3
`define FAWP_WS_RESET 3'h4
`define FAWP_WSE_RESET 1'h1
`define FAWP_MOD_W 3
`define FAWP_NUM_MOD 7
`define FAWP_SPARE_MOD 3'h6
`define FAWP_ADDR_W 24
`define FAWP_DATA_W 32
`define FAWP_LINE_STEP 24'h00_0004
`define FAWP_MOD_SHIFT 18
`define FAWP_OP_ERASE 1'h0
`define FAWP_OP_PROG 1'h1
`define FAWP_ERASE_TIME_US 8000
`define FAWP_PROG_TIME_US 3500
`define FAWP_FCLK_MHZ 5
`define FAWP_ERASE_TICKS ((`FAWP_ERASE_TIME_US * `FAWP_FCLK_MHZ))
`define FAWP_PROG_TICKS ((`FAWP_PROG_TIME_US * `FAWP_FCLK_MHZ))
`define FAWP_OVERHEAD_CYC 4'h4
`define FAWP_ERASED_WORD 32'hFFFF_FFFF
`endif

// ==== fawp_flash_ctrl.v ====
// Flash read path with wait states and prefetch, plus program/erase control
// What this block does
// - Wait states are paid only on non-sequential reads, not on prefetched sequential ones.
// - A prefetch fetches the next word ahead for sequentially increasing addresses.
// - Any modules may be erased or programmed while reads stay in one other module or SRAM.
// - With reads from several modules only module 6 may be erased or programmed.
// - An erase or program aimed at the module supplying reads is refused.
// - A sector or page erase finishes within 8.0 ms of flash clock time.
// - A page program finishes within 3.5 ms of flash clock time.
// - A few system clock cycles of overhead follow the timed operation.
// - After reset rd_data holds the erased word with no read protection active.
`timescale 1ns/10ps
`include "fawp_defines.vh"
module fawp_flash_ctrl #(
  parameter ERASE_TICKS = `FAWP_ERASE_TICKS,
  parameter PROG_TICKS = `FAWP_PROG_TICKS
) (
  input wire clk,
  input wire rst_b,
  input wire flash_clk_tick,
  input wire [`FAWP_WS_W-1:0] flash_wait_states,
  input wire wait_state_extension,
  input wire rd_req,
  input wire [`FAWP_ADDR_W-1:0] rd_addr,
  input wire multi_module_read,
  output reg rd_ack,
  output reg [`FAWP_DATA_W-1:0] rd_data,
  input wire [`FAWP_DATA_W-1:0] array_data,
  output reg [`FAWP_ADDR_W-1:0] array_addr,
  input wire pe_req,
  input wire pe_op,
  input wire [`FAWP_MOD_W-1:0] pe_module,
  output reg pe_busy,
  output reg pe_done,
  output reg pe_refused
);
  localparam S_IDLE = 2'h0;
  localparam S_WAIT = 2'h1;
  localparam S_PREF = 2'h2;
  localparam P_IDLE = 2'h0;
  localparam P_RUN = 2'h1;
  localparam P_OVH = 2'h2;

  reg [1:0] rd_state;
  reg [3:0] wait_cnt;
  reg [`FAWP_ADDR_W-1:0] pf_addr;
  reg [`FAWP_DATA_W-1:0] pf_data;
  reg pf_valid;
  reg [`FAWP_MOD_W-1:0] read_module;
  reg read_seen;
  reg [1:0] pe_state;
  reg [3:0] ovh_cnt;
  reg [`FAWP_MOD_W-1:0] busy_module;
  reg tm_start;
  reg [23:0] tm_ticks;
  wire [(1 << `FAWP_MOD_W)-1:0] read_mask;
  wire tm_done;
  wire [`FAWP_MOD_W-1:0] req_module;
  wire pe_allowed;
  wire read_blocked;

  assign req_module = rd_addr[`FAWP_MOD_SHIFT +: `FAWP_MOD_W];
  // Refuse every module still read, and all but module 6 under multi-module reads
  assign pe_allowed = !(read_seen && pe_module == read_module) &&
    !read_mask[pe_module] &&
    (!multi_module_read || pe_module == `FAWP_SPARE_MOD);
  // Reads into a module under program/erase are held off
  assign read_blocked = pe_busy && req_module == busy_module;

  // One flag per module that supplied reads; kept while reads span several modules
  genvar gm;
  generate
    for (gm = 0; gm < (1 << `FAWP_MOD_W); gm = gm + 1) begin : g_read_mask
      localparam [`FAWP_MOD_W-1:0] MOD_ID = gm;
      reg flag;
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          flag <= 1'b0;
        end else if (read_seen && read_module == MOD_ID) begin
          flag <= 1'b1;
        end else if (!multi_module_read) begin
          flag <= 1'b0;
        end
      end
      assign read_mask[gm] = flag;
    end
  endgenerate

  fawp_tick_timer #(
    .CNT_W(24)
  ) u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .start(tm_start),
    .ticks(tm_ticks),
    .tick_in(flash_clk_tick),
    .busy(),
    .done(tm_done)
  );

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_state <= S_IDLE;
      wait_cnt <= 4'h0;
      pf_addr <= {`FAWP_ADDR_W{1'b0}};
      pf_data <= `FAWP_ERASED_WORD;
      pf_valid <= 1'b0;
      rd_ack <= 1'b0;
      rd_data <= `FAWP_ERASED_WORD;
      array_addr <= {`FAWP_ADDR_W{1'b0}};
      read_module <= {`FAWP_MOD_W{1'b0}};
      read_seen <= 1'b0;
    end else begin
      rd_ack <= 1'b0;
      case (rd_state)
        S_IDLE: begin
          if (rd_req && !rd_ack && !read_blocked) begin
            read_module <= req_module;
            read_seen <= 1'b1;
            if (pf_valid && rd_addr == pf_addr) begin
              // Sequential hit: no wait states
              rd_data <= pf_data;
              rd_ack <= 1'b1;
              pf_valid <= 1'b0;
              pf_addr <= rd_addr + `FAWP_LINE_STEP;
              array_addr <= rd_addr + `FAWP_LINE_STEP;
              wait_cnt <= {1'b0, flash_wait_states};
              rd_state <= S_PREF;
            end else begin
              pf_valid <= 1'b0;
              array_addr <= rd_addr;
              wait_cnt <= {1'b0, flash_wait_states} + {3'h0, wait_state_extension};
              rd_state <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          if (wait_cnt <= 4'h1) begin
            rd_data <= array_data;
            rd_ack <= 1'b1;
            pf_addr <= array_addr + `FAWP_LINE_STEP;
            array_addr <= array_addr + `FAWP_LINE_STEP;
            wait_cnt <= {1'b0, flash_wait_states};
            rd_state <= S_PREF;
          end else begin
            wait_cnt <= wait_cnt - 4'h1;
          end
        end
        S_PREF: begin
          // Background fetch of the next word; a new miss replaces it at once
          if (rd_req && !rd_ack && rd_addr != pf_addr) begin
            if (read_blocked) begin
              rd_state <= S_IDLE;
            end else begin
              read_module <= req_module;
              read_seen <= 1'b1;
              array_addr <= rd_addr;
              wait_cnt <= {1'b0, flash_wait_states} + {3'h0, wait_state_extension};
              rd_state <= S_WAIT;
            end
          end else if (wait_cnt <= 4'h1) begin
            pf_data <= array_data;
            pf_valid <= 1'b1;
            rd_state <= S_IDLE;
          end else begin
            wait_cnt <= wait_cnt - 4'h1;
          end
        end
        default: rd_state <= S_IDLE;
      endcase
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pe_state <= P_IDLE;
      pe_busy <= 1'b0;
      pe_done <= 1'b0;
      pe_refused <= 1'b0;
      ovh_cnt <= 4'h0;
      busy_module <= {`FAWP_MOD_W{1'b0}};
      tm_start <= 1'b0;
      tm_ticks <= 24'h00_0000;
    end else begin
      pe_done <= 1'b0;
      pe_refused <= 1'b0;
      tm_start <= 1'b0;
      case (pe_state)
        P_IDLE: begin
          if (pe_req) begin
            if (pe_allowed) begin
              busy_module <= pe_module;
              pe_busy <= 1'b1;
              tm_start <= 1'b1;
              if (pe_op == `FAWP_OP_PROG) begin
                tm_ticks <= PROG_TICKS[23:0];
              end else begin
                tm_ticks <= ERASE_TICKS[23:0];
              end
              pe_state <= P_RUN;
            end else begin
              pe_refused <= 1'b1;
            end
          end
        end
        P_RUN: begin
          if (tm_done) begin
            ovh_cnt <= `FAWP_OVERHEAD_CYC;
            pe_state <= P_OVH;
          end
        end
        P_OVH: begin
          if (ovh_cnt <= 4'h1) begin
            pe_busy <= 1'b0;
            pe_done <= 1'b1;
            pe_state <= P_IDLE;
          end else begin
            ovh_cnt <= ovh_cnt - 4'h1;
          end
        end
        default: pe_state <= P_IDLE;
      endcase
    end
  end
endmodule // fawp_flash_ctrl

// ==== fawp_flash_ctrl_test.sv ====
// Self-checking bench for the flash control block
`timescale 1ns/10ps
module fawp_flash_ctrl_test;
  reg clk, rst_b, rd_req, multi_module_read, pe_req, pe_op, wait_state_extension;
  reg [2:0] flash_wait_states, pe_module, i;
  reg [23:0] rd_addr;
  wire rd_ack, pe_busy, pe_done, pe_refused, flash_clk_tick;
  wire [31:0] rd_data, array_data;
  wire [23:0] array_addr;
  integer failures = 0;
  integer comparisons = 0;
  fawp_flash_ctrl #(.ERASE_TICKS(10), .PROG_TICKS(5)) fawp_flash_ctrl_inst (.clk, .rst_b,
    .flash_clk_tick, .flash_wait_states, .wait_state_extension, .rd_req, .rd_addr,
    .multi_module_read, .rd_ack, .rd_data, .array_data, .array_addr, .pe_req, .pe_op,
    .pe_module, .pe_busy, .pe_done, .pe_refused);
  fawp_array_model fawp_array_model_inst (.array_addr, .array_data, .flash_clk_tick);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task final_report;
    begin
      if (failures == 0 && comparisons > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task check(input [8*8-1:0] what, input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("Error %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task step(inout integer n);
    begin
      @(posedge clk);
      #1;
      n = n + 1;
      if (n > 400) begin
        failures = failures + 1;
        final_report;
      end
    end
  endtask
  task do_read(input [23:0] a, input integer lat);
    integer n;
    begin
      n = 0;
      rd_addr = a;
      rd_req = 1'b1;
      while (rd_ack !== 1'b1)
        step(n);
      check("latency", n, lat);
      check("rd_data", rd_data, {8'h5A, a});
      rd_req = 1'b0;
    end
  endtask
  task do_pe(input [2:0] m, input op, input multi, input refuse, input integer t);
    integer n;
    begin
      n = 0;
      multi_module_read = multi;
      pe_module = m;
      pe_op = op;
      pe_req = 1'b1;
      step(n);
      pe_req = 1'b0;
      while (pe_refused !== 1'b1 && pe_busy !== 1'b1)
        step(n);
      check("refused", pe_refused, refuse);
      if (!refuse) begin
        while (pe_done !== 1'b1)
          step(n);
        check("pe_time", (n >= 2 * t + 6) && (n <= 2 * t + 7), 1'b1);
      end
      step(n);
    end
  endtask
  // Module 6 was read under multi-module reads, so it must stay protected
  task spare_read_refuse;
    begin
      multi_module_read = 1'b1;
      do_read(24'h18_0000, 6);
      repeat (6) @(posedge clk);
      #1;
      do_read(24'h08_0000, 6);
      do_pe(3'h6, 1'b0, 1'b1, 1'b1, 10);
    end
  endtask
  initial begin
    rst_b = 1'b0;
    rd_req = 1'b0;
    rd_addr = 24'h00_0000;
    multi_module_read = 1'b0;
    pe_req = 1'b0;
    pe_op = 1'b0;
    pe_module = 3'h0;
    flash_wait_states = 3'h4;
    wait_state_extension = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    rst_b = 1'b1;
    check("rst_data", rd_data, 32'hFFFF_FFFF);
    for (i = 3'h1; i <= 3'h4; i = i + 3'h1) begin
      flash_wait_states = i;
      wait_state_extension = (i == 3'h4);
      do_read({14'h0200, i, 7'h00}, 1 + i + (i == 3'h4));
      repeat (i + 2) @(posedge clk);
      #1;
      do_read({14'h0200, i, 7'h04}, 1);
      // Next miss lands while the background fetch may still run
      @(posedge clk);
      #1;
    end
    do_pe(3'h2, 1'b0, 1'b0, 1'b1, 10);
    do_pe(3'h3, 1'b0, 1'b0, 1'b0, 10);
    do_pe(3'h3, 1'b1, 1'b1, 1'b1, 5);
    do_pe(3'h6, 1'b1, 1'b1, 1'b0, 5);
    spare_read_refuse;
    final_report;
  end
endmodule // fawp_flash_ctrl_test

// ==== fawp_tick_timer.v ====
// Program/erase duration timer counting synchronised flash clock ticks
`timescale 1ns/10ps
module fawp_tick_timer #(
  parameter CNT_W = 16
) (
  input wire clk,
  input wire rst_b,
  input wire start,
  input wire [CNT_W-1:0] ticks,
  input wire tick_in,
  output reg busy,
  output reg done
);
  reg [CNT_W-1:0] count;
  reg tick_s1;
  reg tick_s2;
  reg tick_s3;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_s1 <= 1'b0;
      tick_s2 <= 1'b0;
      tick_s3 <= 1'b0;
      count <= {CNT_W{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      tick_s1 <= tick_in;
      tick_s2 <= tick_s1;
      tick_s3 <= tick_s2;
      done <= 1'b0;
      if (start) begin
        count <= ticks;
        busy <= 1'b1;
      end else if (busy && tick_s2 && !tick_s3) begin
        if (count <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        count <= count - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // fawp_tick_timer
